/* File: design/sfhps_pkg.sv */
// shared constants and types for the serial flash hold, protect and status block
package sfhps_pkg;

  // ----------------------------------------------------------------
  // instruction opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLOCK_ERASE  = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OPC_BYTE_PROG    = 8'h02;
  localparam logic [7:0] OPC_AUTO_INC     = 8'had;

  // ----------------------------------------------------------------
  // frame lengths in whole bytes, opcode included
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_ONE      = 3'h1;
  localparam logic [2:0] LEN_STATUS_W = 3'h2;
  localparam logic [2:0] LEN_AAI_NEXT = 3'h3;
  localparam logic [2:0] LEN_ERASE    = 3'h4;
  localparam logic [2:0] LEN_PROG     = 3'h5;
  localparam logic [2:0] LEN_AAI_FIRST = 3'h6;
  localparam logic [2:0] LEN_NONE     = 3'h0;

  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_WEL   = 1;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_BP_HI = 4;
  localparam int unsigned ST_AAI   = 6;
  localparam int unsigned ST_LOCK  = 7;
  localparam logic [7:0]  ST_RESET = 8'h1c;
  localparam logic [2:0]  BP_RESET = 3'h7;
  localparam logic [2:0]  BP_NONE  = 3'h0;

  // ----------------------------------------------------------------
  // array geometry and timing
  // ----------------------------------------------------------------
  localparam logic [5:0]  BLOCK_COUNT  = 6'h20;
  localparam logic [23:0] AAI_STEP     = 24'h00_0002;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_PROG_NS    = 7000;
  localparam int unsigned T_SECTOR_MS  = 60;
  localparam int unsigned T_BLOCK_MS   = 1000;
  localparam int unsigned T_CHIP_MS    = 10000;
  localparam int unsigned CYC_PER_MS   = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC     = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SFHPS_OP_NONE, SFHPS_OP_BYTE, SFHPS_OP_WORD, SFHPS_OP_SECTOR, SFHPS_OP_BLOCK, SFHPS_OP_CHIP
  } sfhps_op_t;

endpackage

/* File: design/sfhps_top.sv */
// serial flash hold, write protect, status register and instruction framing
//
// Function
// - pause entry on pause fall, clock low
// - pause exit on pause rise, clock low
// - paused: output floats, inputs ignored
// - chip-select high resets logic, pause persists
// - status write blocked when protect low, locked
// - bit 0 busy, read-only, zero at reset
// - bit 1 write latch, read-only
// - bits 2-4 protection level, reset ones
// - bit 5 reads zero, never written
// - bit 6 auto-increment mode, read-only
// - lock bit freezes level while protect low, resets zero
// - writes load only level and lock, and clear the latch
// - all status bits reload at reset
// - while busy only status reads act
// - latch clear: program and erase ignored
// - latch cleared on listed completions
// - instruction starts at select falling edge
// - input sampled rising edge, msb first
// - early select rise aborts instruction
// - level protects upper blocks from change
// - chip erase only with level zero
// - status read repeats until select rises
`timescale 1ns/1ns
`default_nettype none

module sfhps_top #(
  parameter int unsigned SECTOR_CYC = sfhps_pkg::T_SECTOR_MS * sfhps_pkg::CYC_PER_MS,
  parameter int unsigned BLOCK_CYC  = sfhps_pkg::T_BLOCK_MS * sfhps_pkg::CYC_PER_MS,
  parameter int unsigned CHIP_CYC   = sfhps_pkg::T_CHIP_MS * sfhps_pkg::CYC_PER_MS
) (
  input  wire logic                 clk,             // system clock, 50 MHz
  input  wire logic                 reset_n,         // async reset, power-up
  input  wire logic                 sck,             // serial clock from host
  input  wire logic                 cs_n,            // chip select
  input  wire logic                 serial_in,       // serial data in
  input  wire logic                 pause_n,         // pause input
  input  wire logic                 write_protect_n, // write protect pin
  output logic                      serial_out,      // serial data out
  output logic                      serial_out_oe_n, // low while driving serial_out
  output logic [7:0]                flash_status,    // live status register
  output logic                      op_start,        // one-cycle array operation start
  output sfhps_pkg::sfhps_op_t      op_kind,         // array operation kind
  output logic [23:0]               op_addr,         // array operation address
  output logic [15:0]               op_data          // program data, word or low byte
);

  // ----------------------------------------------------------------
  // pause tracking on the serial clock
  // ----------------------------------------------------------------
  logic hold_q;
  logic paused;
  logic link_clr_n;

  // state during clock high is frozen from the last low phase
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= ~pause_n;
    end
  end

  // while the clock is low the pause level acts at once
  assign paused     = sck ? hold_q : ~pause_n;
  assign link_clr_n = reset_n & ~cs_n;

  // ----------------------------------------------------------------
  // link-side receiver
  // ----------------------------------------------------------------
  logic [2:0]  bit_q;
  logic [2:0]  byte_q;
  logic        rd_q;
  logic [47:0] sh_q;
  logic [7:0]  op_q;
  logic        ok_q;
  logic        tog_q;
  logic [7:0]  stat_s1_q;
  logic [7:0]  stat_s2_q;
  logic [7:0]  op_in;
  logic [2:0]  need;
  logic        byte_end;
  logic        ok_d;

  function automatic logic [2:0] need_of(input logic [7:0] op, input logic auto_increment_prog);
    logic [2:0] n;
    n = sfhps_pkg::LEN_NONE;
    case (op)
      sfhps_pkg::OPC_WRITE_ENABLE,
      sfhps_pkg::OPC_WRITE_DISABLE,
      sfhps_pkg::OPC_CHIP_ERASE_A,
      sfhps_pkg::OPC_CHIP_ERASE_B: n = sfhps_pkg::LEN_ONE;
      sfhps_pkg::OPC_STATUS_WRITE: n = sfhps_pkg::LEN_STATUS_W;
      sfhps_pkg::OPC_SECTOR_ERASE,
      sfhps_pkg::OPC_BLOCK_ERASE:  n = sfhps_pkg::LEN_ERASE;
      sfhps_pkg::OPC_BYTE_PROG:    n = sfhps_pkg::LEN_PROG;
      sfhps_pkg::OPC_AUTO_INC:     n = auto_increment_prog ? sfhps_pkg::LEN_AAI_NEXT : sfhps_pkg::LEN_AAI_FIRST;
      default:                     n = sfhps_pkg::LEN_NONE;
    endcase
    return n;
  endfunction

  assign byte_end = (bit_q == 3'h7);
  assign op_in    = (byte_end && byte_q == 3'h0) ? {sh_q[6:0], serial_in} : op_q;
  assign need     = need_of(op_in, stat_s2_q[sfhps_pkg::ST_AAI]);
  // a frame is complete only when the last bit closes the last byte
  assign ok_d     = byte_end && (byte_q != 3'h7) && ((byte_q + 3'h1) == need);

  // counters clear whenever select is high, so each frame opens fresh;
  // at a rising edge the pin level is what held through the low phase just
  // ended, whereas the combinational pause view would race the edge itself
  always_ff @(posedge sck or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_q  <= 3'h0;
      byte_q <= 3'h0;
      rd_q   <= 1'b0;
    end else if (pause_n) begin
      bit_q <= bit_q + 3'h1;
      if (byte_end && byte_q != 3'h7) begin
        byte_q <= byte_q + 3'h1;
      end
      if (byte_end && byte_q == 3'h0 && op_in == sfhps_pkg::OPC_STATUS_READ) begin
        rd_q <= 1'b1;
      end
    end
  end

  // fields survive the select rise so the system side can still read them
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      sh_q  <= 48'h0000_0000_0000;
      op_q  <= 8'h00;
      ok_q  <= 1'b0;
      tog_q <= 1'b0;
    end else if (pause_n) begin
      sh_q <= {sh_q[46:0], serial_in};
      op_q <= op_in;
      ok_q <= ok_d;
      if (bit_q == 3'h0 && byte_q == 3'h0) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // status snapshot for the shifter; sck idles between frames, but the
  // opcode byte alone gives it more than enough edges to settle
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      stat_s1_q <= sfhps_pkg::ST_RESET;
      stat_s2_q <= sfhps_pkg::ST_RESET;
    end else begin
      stat_s1_q <= flash_status;
      stat_s2_q <= stat_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // link-side transmitter
  // ----------------------------------------------------------------
  logic [2:0] tx_bit_q;
  logic       so_q;

  always_ff @(negedge sck or negedge link_clr_n) begin
    if (!link_clr_n) begin
      tx_bit_q <= 3'h0;
      so_q     <= 1'b0;
    end else if (rd_q && !hold_q) begin
      so_q     <= stat_s2_q[3'h7 - tx_bit_q];
      tx_bit_q <= tx_bit_q + 3'h1;
    end
  end

  assign serial_out      = so_q;
  assign serial_out_oe_n = ~(rd_q & ~paused & ~cs_n);

  // ----------------------------------------------------------------
  // crossing into the system clock
  // ----------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic tog_s1_q, tog_s2_q, seen_q;
  logic ok_s1_q, ok_s2_q;
  logic wp_s1_q, wp_s2_q;
  logic go;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      ok_s1_q  <= 1'b0;
      ok_s2_q  <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      ok_s1_q  <= ok_q;
      ok_s2_q  <= ok_s1_q;
      wp_s1_q  <= write_protect_n;
      wp_s2_q  <= wp_s1_q;
    end
  end

  // an instruction runs once, at the select rise that closes its frame
  assign go = cs_s2_q & ~cs_s3_q & (tog_s2_q != seen_q) & ok_s2_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_q <= 1'b0;
    end else if (cs_s2_q && !cs_s3_q) begin
      seen_q <= tog_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic        busy;
  logic        wel_q, aai_q, lock_q;
  logic [2:0]  bp_q;
  logic [31:0] busy_cnt_q;
  logic [23:0] aai_addr_q;
  logic        accept, is_write_enable_cmd, is_write_disable_cmd, is_status_write_cmd, is_se, is_be, is_ce, is_bp, is_aai;
  logic        is_mem, status_write_cmd_ok, prot_hit, mem_ok, done, aai_last;
  logic [23:0] mem_addr, aai_next;
  logic [15:0] mem_data;

  assign busy    = (busy_cnt_q != 32'h0000_0000);
  assign accept  = go & ~busy;
  assign is_write_enable_cmd = (op_q == sfhps_pkg::OPC_WRITE_ENABLE);
  assign is_write_disable_cmd = (op_q == sfhps_pkg::OPC_WRITE_DISABLE);
  assign is_status_write_cmd = (op_q == sfhps_pkg::OPC_STATUS_WRITE);
  assign is_se   = (op_q == sfhps_pkg::OPC_SECTOR_ERASE);
  assign is_be   = (op_q == sfhps_pkg::OPC_BLOCK_ERASE);
  assign is_ce   = (op_q == sfhps_pkg::OPC_CHIP_ERASE_A) | (op_q == sfhps_pkg::OPC_CHIP_ERASE_B);
  assign is_bp   = (op_q == sfhps_pkg::OPC_BYTE_PROG);
  assign is_aai  = (op_q == sfhps_pkg::OPC_AUTO_INC);
  assign is_mem  = is_se | is_be | is_ce | is_bp | is_aai;

  assign status_write_cmd_ok = wp_s2_q | ~lock_q;

  assign mem_addr = is_bp  ? sh_q[31:8]  :
                    is_aai ? (aai_q ? aai_addr_q : sh_q[39:16]) :
                    sh_q[23:0];
  assign mem_data = is_bp ? {8'h00, sh_q[7:0]} : sh_q[15:0];

  // top-variant map: level n guards the upper 2^(n-1) blocks
  function automatic logic prot_of(input logic [23:0] a, input logic [2:0] lv);
    logic [5:0] s;
    s = 6'h01 << (lv - 3'h1);
    prot_of = (lv == sfhps_pkg::BP_NONE) ? 1'b0 :
              (lv > 3'h5) ? 1'b1 :
              (({1'b0, a[20:16]} + s) >= sfhps_pkg::BLOCK_COUNT);
  endfunction

  assign prot_hit = prot_of(mem_addr, bp_q);
  assign mem_ok   = accept & is_mem & wel_q &
                    (is_ce ? (bp_q == sfhps_pkg::BP_NONE) : ~prot_hit);
  assign done     = (busy_cnt_q == 32'h0000_0001);
  assign aai_next = aai_addr_q + sfhps_pkg::AAI_STEP;
  assign aai_last = (aai_next < aai_addr_q) | prot_of(aai_next, bp_q);

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic wel_d;

  // a refused memory command still consumes the latch, a choice that keeps
  // a stale enable from leaking onto the next program
  assign wel_d = (accept & is_write_enable_cmd)                      ? 1'b1 :
                 (accept & (is_write_disable_cmd | is_status_write_cmd))          ? 1'b0 :
                 (accept & is_mem & wel_q & ~mem_ok)     ? 1'b0 :
                 (done & (~aai_q | aai_last))            ? 1'b0 :
                 wel_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wel_q  <= 1'b0;
      bp_q   <= sfhps_pkg::BP_RESET;
      lock_q <= 1'b0;
    end else begin
      wel_q <= wel_d;
      if (accept && is_status_write_cmd && status_write_cmd_ok) begin
        bp_q   <= sh_q[sfhps_pkg::ST_BP_HI:sfhps_pkg::ST_BP_LO];
        lock_q <= sh_q[sfhps_pkg::ST_LOCK];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aai_q      <= 1'b0;
      aai_addr_q <= 24'h00_0000;
    end else if (accept && is_write_disable_cmd) begin
      aai_q <= 1'b0;
    end else if (mem_ok && is_aai) begin
      aai_q      <= 1'b1;
      aai_addr_q <= mem_addr;
    end else if (done && aai_q) begin
      aai_q      <= ~aai_last;
      aai_addr_q <= aai_next;
    end
  end

  // bit 5 is wired to zero; the write path never reaches it
  assign flash_status = {lock_q, aai_q, 1'b0, bp_q, wel_q, busy};

  // ----------------------------------------------------------------
  // busy timer and array operation request
  // ----------------------------------------------------------------
  logic [31:0] load_cyc;
  sfhps_pkg::sfhps_op_t kind_d;

  assign kind_d   = is_se  ? sfhps_pkg::SFHPS_OP_SECTOR :
                    is_be  ? sfhps_pkg::SFHPS_OP_BLOCK  :
                    is_ce  ? sfhps_pkg::SFHPS_OP_CHIP   :
                    is_aai ? sfhps_pkg::SFHPS_OP_WORD   :
                    sfhps_pkg::SFHPS_OP_BYTE;
  assign load_cyc = is_se ? SECTOR_CYC :
                    is_be ? BLOCK_CYC  :
                    is_ce ? CHIP_CYC   :
                    sfhps_pkg::PROG_CYC;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 32'h0000_0000;
    end else if (mem_ok) begin
      busy_cnt_q <= load_cyc;
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_start <= 1'b0;
      op_kind  <= sfhps_pkg::SFHPS_OP_NONE;
      op_addr  <= 24'h00_0000;
      op_data  <= 16'h0000;
    end else begin
      op_start <= mem_ok;
      if (mem_ok) begin
        op_kind <= kind_d;
        op_addr <= mem_addr;
        op_data <= mem_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_locked_write;
    accept && is_status_write_cmd && !wp_s2_q && lock_q;
  endsequence

  sequence s_free_write;
    accept && is_status_write_cmd && status_write_cmd_ok;
  endsequence

  a_locked_write_held: assert property (@(posedge clk) disable iff (!reset_n)
    s_locked_write |=> $stable(bp_q) && $stable(lock_q) && !wel_q)
    else $error("locked status write changed protection");

  a_free_write_loads: assert property (@(posedge clk) disable iff (!reset_n)
    s_free_write |=> (bp_q == $past(sh_q[4:2])) && (lock_q == $past(sh_q[7])))
    else $error("allowed status write did not load level and lock");

  a_write_enable_cmd_sets_latch: assert property (@(posedge clk) disable iff (!reset_n)
    accept && is_write_enable_cmd |=> wel_q ##0 flash_status[1])
    else $error("write enable did not set the latch");

  a_start_needs_wel: assert property (@(posedge clk) disable iff (!reset_n)
    op_start |-> $past(wel_q))
    else $error("array operation started without write enable");

  a_chip_erase_gate: assert property (@(posedge clk) disable iff (!reset_n)
    op_start && op_kind == sfhps_pkg::SFHPS_OP_CHIP |-> $past(bp_q) == 3'h0)
    else $error("chip erase started while a level was set");

  a_busy_ignores: assert property (@(posedge clk) disable iff (!reset_n)
    busy && go |=> $stable(bp_q) && $stable(lock_q) && !op_start)
    else $error("command acted while busy");

  a_prog_busy_span: assert property (@(posedge clk) disable iff (!reset_n)
    op_start && op_kind == sfhps_pkg::SFHPS_OP_BYTE |-> flash_status[0] [*8])
    else $error("busy did not hold after a byte program start");

  a_done_clears_wel: assert property (@(posedge clk) disable iff (!reset_n)
    done && !aai_q |=> !wel_q)
    else $error("latch still set after operation end");

  a_paused_floats: assert property (@(posedge clk) disable iff (!reset_n)
    paused |-> serial_out_oe_n)
    else $error("serial output driven while paused");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    s_free_write |=> !flash_status[5])
    else $error("reserved status bit became set");

endmodule // sfhps_top

`default_nettype wire

/* File: bench/sfhps_host.sv */
// host controller model driving the serial flash link
`timescale 1ns/1ns
`default_nettype none

module sfhps_host (
  output var logic sck,             // serial clock, runs only inside frames
  output var logic cs_n,            // chip select
  output var logic serial_in,       // serial data to the device
  output var logic pause_n,         // pause input
  input  wire logic serial_out,     // serial data from the device
  input  wire logic serial_out_oe_n,// low while the device drives
  output var logic pause_oe_n       // enable seen while paused
);
  initial begin
    sck        = 1'b0;
    cs_n       = 1'b1;
    serial_in  = 1'b0;
    pause_n    = 1'b1;
    pause_oe_n = 1'b0;
  end

  // ------------------------------------------------------------
  // pause gap: junk clocks and data must be ignored meanwhile
  // ------------------------------------------------------------
  task automatic pause_gap();
    int k;
    pause_n = 1'b0;
    #3 pause_oe_n = serial_out_oe_n;
    for (k = 0; k < 4; k++) begin
      serial_in = ~serial_in;
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
    pause_n = 1'b1;
    #3;
  endtask

  // ------------------------------------------------------------
  // one frame: nbits from the top of tx, then nrd read clocks
  // ------------------------------------------------------------
  task automatic frame(input logic [47:0] tx, input int nbits, input int nrd,
                       input int pause_at, output logic [15:0] rx);
    int i;
    rx   = 16'h0000;
    cs_n = 1'b0;
    for (i = 0; i < nbits + nrd; i++) begin
      if (i == pause_at) pause_gap();
      // released data toggles so a stale level is never mistaken for data
      serial_in = (i < nbits) ? tx[47 - i] : ~serial_in;
      #3 sck = 1'b1;
      if (i >= nbits) rx = {rx[14:0], serial_out};
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    serial_in = ~serial_in;
    #100; // select high time well over 80 ns
  endtask
endmodule // sfhps_host

`default_nettype wire

/* File: bench/sfhps_top_test.sv */
// self-checking bench for the serial flash hold, protect and status block
`timescale 1ns/1ns
`default_nettype none

module sfhps_top_test;
  localparam int unsigned SECTOR_N = 20;
  localparam int unsigned CHIP_N   = 40;
  logic                 clk, reset_n, write_protect_n;
  logic                 sck, cs_n, serial_in, pause_n, pause_oe_n;
  logic                 serial_out, serial_out_oe_n, op_start;
  logic [7:0]           flash_status;
  sfhps_pkg::sfhps_op_t op_kind;
  logic [23:0]          op_addr;
  logic [15:0]          op_data, rx;
  logic [23:0]          last_addr;
  logic [7:0]           last_kind;
  int                   n_mismatch, checks;
  int                   n_ops = 0;
  int                   busy_len = 0;

  sfhps_top #(.SECTOR_CYC(SECTOR_N), .BLOCK_CYC(30), .CHIP_CYC(CHIP_N)) sfhps_top_inst (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .serial_in(serial_in),
    .pause_n(pause_n), .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .flash_status(flash_status), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data));

  sfhps_host sfhps_host_inst (
    .sck(sck), .cs_n(cs_n), .serial_in(serial_in), .pause_n(pause_n),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .pause_oe_n(pause_oe_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (flash_status[0] === 1'b1) busy_len <= busy_len + 1;
    if (op_start === 1'b1) begin
      n_ops     <= n_ops + 1;
      last_kind <= {5'h00, op_kind};
      last_addr <= op_addr;
    end
  end

  // ------------------------------------------------------------
  // compare tasks and closing
  // ------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmd(input logic [47:0] tx, input int nbits, input int nrd, input int p_at);
    @(posedge clk);
    #2;
    sfhps_host_inst.frame(tx, nbits, nrd, p_at, rx);
    repeat (4) @(posedge clk);
  endtask
  task automatic wsr(input logic [7:0] d, input int nbits);
    cmd({sfhps_pkg::OPC_STATUS_WRITE, d, 32'h0000_0000}, nbits, 0, -1);
  endtask
  task automatic one(input logic [7:0] opc);
    cmd({opc, 40'h00_0000_0000}, 8, 0, -1);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && flash_status[0] !== 1'b0; k++) @(posedge clk);
    chk8({7'h00, flash_status[0]}, 8'h00);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write_lock();
    chk8(flash_status, 8'h1c);
    wsr(8'hff, 16);
    chk8(flash_status, 8'h9c);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    chk8(flash_status, 8'h9e);
    #2 write_protect_n = 1'b0;
    wsr(8'h00, 16);
    chk8(flash_status, 8'h9c);
    #2 write_protect_n = 1'b1;
    wsr(8'h04, 16);
    chk8(flash_status, 8'h04);
    #2 write_protect_n = 1'b0;
    wsr(8'h18, 15);
    chk8(flash_status, 8'h04);
  endtask

  task automatic t_pause_read();
    cmd({sfhps_pkg::OPC_STATUS_WRITE, 8'h84, 32'h0000_0000}, 16, 0, 8);
    chk8(flash_status, 8'h84);
    cmd({sfhps_pkg::OPC_STATUS_READ, 40'h00_0000_0000}, 8, 16, 12);
    chk24({8'h00, rx}, 24'h00_8484);
    chk8({7'h00, pause_oe_n}, 8'h01);
    #2 write_protect_n = 1'b1;
    wsr(8'h04, 16);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    one(sfhps_pkg::OPC_WRITE_DISABLE);
    chk8(flash_status, 8'h04);
  endtask

  task automatic t_array();
    int b0;
    cmd({sfhps_pkg::OPC_SECTOR_ERASE, 24'h00_1000, 16'h0000}, 32, 0, -1);
    chk8(n_ops[7:0], 8'h00);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    cmd({sfhps_pkg::OPC_SECTOR_ERASE, 24'h1f_0000, 16'h0000}, 32, 0, -1);
    chk8(flash_status, 8'h04);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    one(sfhps_pkg::OPC_CHIP_ERASE_A);
    chk8(n_ops[7:0], 8'h00);
    wsr(8'h00, 16);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    b0 = busy_len;
    cmd({sfhps_pkg::OPC_SECTOR_ERASE, 24'h00_1000, 16'h0000}, 32, 0, -1);
    wait_idle();
    chk8(last_kind, {5'h00, sfhps_pkg::SFHPS_OP_SECTOR});
    chk24(last_addr, 24'h00_1000);
    chk24(24'(busy_len - b0), 24'(SECTOR_N));
    chk8(flash_status, 8'h00);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    b0 = busy_len;
    one(sfhps_pkg::OPC_CHIP_ERASE_B);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    wait_idle();
    chk8(last_kind, {5'h00, sfhps_pkg::SFHPS_OP_CHIP});
    chk24(24'(busy_len - b0), 24'(CHIP_N));
    chk8(flash_status, 8'h00);
  endtask

  task automatic t_program();
    int b0;
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    b0 = busy_len;
    cmd({sfhps_pkg::OPC_BYTE_PROG, 24'h01_2345, 8'ha5, 8'h00}, 40, 0, -1);
    wait_idle();
    chk8(last_kind, {5'h00, sfhps_pkg::SFHPS_OP_BYTE});
    chk24(last_addr, 24'h01_2345);
    chk24({8'h00, op_data}, 24'h00_00a5);
    chk24(24'(busy_len - b0), 24'(sfhps_pkg::PROG_CYC));
    chk8(flash_status, 8'h00);
    one(sfhps_pkg::OPC_WRITE_ENABLE);
    cmd({sfhps_pkg::OPC_AUTO_INC, 24'h00_0100, 16'h1234}, 48, 0, -1);
    chk8(flash_status, 8'h43);
    wait_idle();
    chk24({8'h00, op_data}, 24'h00_1234);
    chk8(flash_status, 8'h42);
    one(sfhps_pkg::OPC_WRITE_DISABLE);
    chk8(flash_status, 8'h00);
  endtask

  initial begin
    reset_n         = 1'b0;
    write_protect_n = 1'b1;
    n_mismatch      = 0;
    checks          = 0;
    repeat (16) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    t_write_lock();
    t_pause_read();
    t_array();
    t_program();
    final_report();
  end

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule // sfhps_top_test

`default_nettype wire
